// ==== verilog/dpc_pkg.sv ====
// Constants, field layouts and carrier types for the dual prescaled down-counter.
// Assumes a single 50 MHz core clock and a byte-wide register file port.
package dpc_pkg;
	localparam logic [7:0] DPC_MODE_ADDR   = 8'hf1;
	localparam logic [7:0] DPC_CNT_B_ADDR  = 8'hf2;
	localparam logic [7:0] DPC_PRE_B_ADDR  = 8'hf3;
	localparam logic [7:0] DPC_CNT_A_ADDR  = 8'hf4;
	localparam logic [7:0] DPC_PRE_A_ADDR  = 8'hf5;
	localparam int         DPC_LOAD_A_BIT  = 0;
	localparam int         DPC_EN_A_BIT    = 1;
	localparam int         DPC_LOAD_B_BIT  = 2;
	localparam int         DPC_EN_B_BIT    = 3;
	localparam int         DPC_TOUT_LO_BIT = 6;
	localparam int         DPC_TOUT_HI_BIT = 7;
	localparam int         DPC_CONT_BIT    = 0;
	localparam int         DPC_EXT_BIT     = 1;
	localparam int         DPC_MOD_LSB     = 2;
	localparam logic [7:0] DPC_PRE_READ    = 8'hff;
	localparam logic [7:0] DPC_MODE_RST    = 8'h00;
	localparam logic [7:0] DPC_PRE_RST     = 8'hfc;
	localparam logic [7:0] DPC_CNT_RST     = 8'h00;
	localparam logic [1:0] DPC_TDIV_MAX    = 2'h3;
	localparam int         DPC_OSC_DIV     = 2;
	localparam int         DPC_CLK_MHZ     = 50;
	// Counter channel control, one per counter
	typedef struct packed {
		logic       load;
		logic       enable;
		logic       cont;
		logic [5:0] modulus;
		logic [7:0] initial_cnt;
	} dpc_chan_ctl_t;
	// Counter channel status
	typedef struct packed {
		logic       eoc;
		logic [7:0] count;
	} dpc_chan_sts_t;
endpackage

// ==== verilog/dpc_tick_gen.sv ====
// Timer clock generator: divide-by-four tick from the internal clock.
// Assumes the internal clock is already the oscillator divided by two.
`timescale 1ns/1ps
`default_nettype none
module dpc_tick_gen (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Tick out
	output logic      timer_tick
);
	import dpc_pkg::*;
	logic [1:0] div_reg;
	assign timer_tick = (div_reg == DPC_TDIV_MAX);
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	a_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_b)
		timer_tick |=> !timer_tick [*3] ##1 timer_tick)
		else $error("Timer tick period is not four clocks");
endmodule // dpc_tick_gen
`default_nettype wire

// ==== verilog/dpc_channel.sv ====
// One prescaler plus 8-bit down-counter channel.
// Assumes tick is a one-cycle strobe in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dpc_channel (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	// Control
	input  wire logic                   tick,
	input  wire dpc_pkg::dpc_chan_ctl_t ctl,
	// Status
	output dpc_pkg::dpc_chan_sts_t      sts
);
	import dpc_pkg::*;
	logic [5:0] pre_reg;
	logic [7:0] cnt_reg;
	logic       stopped_reg;
	wire        pre_tc  = (pre_reg == 6'h01) || (pre_reg == 6'h00);
	wire        cnt_tc  = (cnt_reg == 8'h01);
	wire        run     = ctl.enable && !stopped_reg && tick;
	wire        eoc     = run && pre_tc && cnt_tc;
	assign sts.count = cnt_reg;
	assign sts.eoc   = eoc;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_reg     <= 6'h3f;
			cnt_reg     <= 8'h00;
			stopped_reg <= 1'b1;
		end else if (ctl.load) begin
			pre_reg     <= ctl.modulus;
			cnt_reg     <= ctl.initial_cnt;
			stopped_reg <= 1'b0;
		end else if (run) begin
			pre_reg <= pre_tc ? ctl.modulus : pre_reg - 6'h01;
			if (pre_tc) begin
				if (!cnt_tc) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else if (ctl.cont) begin
					cnt_reg <= ctl.initial_cnt;
				end else begin
					cnt_reg     <= 8'h00;
					stopped_reg <= 1'b1;
				end
			end
		end
	end
	a_hold_disabled: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!ctl.enable && !ctl.load |=> $stable(cnt_reg))
		else $error("Counter moved while disabled");
	a_single_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
		eoc && !ctl.cont && !ctl.load |=> cnt_reg == 8'h00 && stopped_reg)
		else $error("Single pass did not stop at zero");
	a_cont_reload: assert property (@(posedge ref_clk) disable iff (!rst_b)
		eoc && ctl.cont && !ctl.load |=> cnt_reg == $past(ctl.initial_cnt))
		else $error("Continuous mode did not reload");
	a_load_copy: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ctl.load |=> cnt_reg == $past(ctl.initial_cnt) && pre_reg == $past(ctl.modulus))
		else $error("Load did not copy initial values");
	a_no_carry_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		run && !pre_tc && !ctl.load |=> $stable(cnt_reg) && pre_reg == $past(pre_reg) - 6'h01)
		else $error("Counter moved without prescaler carry");
endmodule // dpc_channel
`default_nettype wire

// ==== verilog/dpc_top.sv ====
// Dual prescaled down-counter: register file port, channels and timer output.
// Assumes a byte register port with one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
module dpc_top (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Register file port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// External count input pin
	input  wire logic       external_count_input,
	// Interrupt requests and timer output
	output logic            counter_a_irq,
	output logic            counter_b_irq,
	output logic            timer_output
);
	import dpc_pkg::*;
	logic [7:0]    mode_reg;
	logic [7:0]    pre_a_reg;
	logic [7:0]    pre_b_reg;
	logic [7:0]    init_a_reg;
	logic [7:0]    init_b_reg;
	logic [2:0]    ext_sync_reg;
	logic [1:0]    en_hist_reg;
	logic          irq_a_reg;
	logic          irq_b_reg;
	logic          tout_reg;
	logic [7:0]    rdata_reg;
	logic          tick_int;
	dpc_chan_ctl_t ctl_a;
	dpc_chan_ctl_t ctl_b;
	dpc_chan_sts_t sts_a;
	dpc_chan_sts_t sts_b;
	// Decoding
	wire wr_mode  = reg_wr && (reg_addr == DPC_MODE_ADDR);
	wire wr_cnt_b = reg_wr && (reg_addr == DPC_CNT_B_ADDR);
	wire wr_pre_b = reg_wr && (reg_addr == DPC_PRE_B_ADDR);
	wire wr_cnt_a = reg_wr && (reg_addr == DPC_CNT_A_ADDR);
	wire wr_pre_a = reg_wr && (reg_addr == DPC_PRE_A_ADDR);
	// Synchronised external edge, falling
	wire ext_fall = ext_sync_reg[2] && !ext_sync_reg[1];
	wire ext_sel  = pre_b_reg[DPC_EXT_BIT];
	wire tick_b   = ext_sel ? ext_fall : tick_int;
	wire [1:0] tout_sel = mode_reg[DPC_TOUT_HI_BIT:DPC_TOUT_LO_BIT];
	wire [7:0] mode_next = {mode_reg[7:4], mode_reg[DPC_EN_B_BIT], 1'b0,
	                        mode_reg[DPC_EN_A_BIT], 1'b0};
	wire [7:0] rd_mux = (reg_addr == DPC_MODE_ADDR)  ? mode_reg :
	                    (reg_addr == DPC_CNT_A_ADDR) ? sts_a.count :
	                    (reg_addr == DPC_CNT_B_ADDR) ? sts_b.count :
	                    DPC_PRE_READ;
	// Channel control
	assign ctl_a.load        = mode_reg[DPC_LOAD_A_BIT];
	assign ctl_a.enable      = mode_reg[DPC_EN_A_BIT];
	assign ctl_a.cont        = pre_a_reg[DPC_CONT_BIT];
	assign ctl_a.modulus     = pre_a_reg[7:DPC_MOD_LSB];
	assign ctl_a.initial_cnt = init_a_reg;
	assign ctl_b.load        = mode_reg[DPC_LOAD_B_BIT];
	assign ctl_b.enable      = mode_reg[DPC_EN_B_BIT];
	assign ctl_b.cont        = pre_b_reg[DPC_CONT_BIT];
	assign ctl_b.modulus     = pre_b_reg[7:DPC_MOD_LSB];
	assign ctl_b.initial_cnt = init_b_reg;
	assign reg_rdata     = rdata_reg;
	assign counter_a_irq = irq_a_reg;
	assign counter_b_irq = irq_b_reg;
	assign timer_output  = tout_reg;
	dpc_tick_gen u_tick (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.timer_tick (tick_int)
	);
	dpc_channel u_chan_a (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.tick    (tick_int),
		.ctl     (ctl_a),
		.sts     (sts_a)
	);
	dpc_channel u_chan_b (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.tick    (tick_b),
		.ctl     (ctl_b),
		.sts     (sts_b)
	);
	// Mode register: load bits self-clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= DPC_MODE_RST;
		end else if (wr_mode) begin
			mode_reg <= reg_wdata;
		end else begin
			mode_reg <= mode_next;
		end
	end
	// Initial value and prescaler registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_a_reg  <= DPC_PRE_RST;
			pre_b_reg  <= DPC_PRE_RST;
			init_a_reg <= DPC_CNT_RST;
			init_b_reg <= DPC_CNT_RST;
		end else begin
			if (wr_pre_a) pre_a_reg <= reg_wdata;
			if (wr_pre_b) pre_b_reg <= reg_wdata;
			if (wr_cnt_a) init_a_reg <= reg_wdata;
			if (wr_cnt_b) init_b_reg <= reg_wdata;
		end
	end
	// Pin synchroniser
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_sync_reg <= 3'h7;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], external_count_input};
		end
	end
	// Read data, interrupt pulses, timer output toggle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg   <= 8'h00;
			irq_a_reg   <= 1'b0;
			irq_b_reg   <= 1'b0;
			tout_reg    <= 1'b1;
			en_hist_reg <= 2'h0;
		end else begin
			if (reg_rd) rdata_reg <= rd_mux;
			irq_a_reg   <= sts_a.eoc;
			irq_b_reg   <= sts_b.eoc;
			en_hist_reg <= {mode_reg[DPC_EN_B_BIT], mode_reg[DPC_EN_A_BIT]};
			if ((tout_sel == 2'h1 && mode_reg[DPC_LOAD_A_BIT]) ||
			    (tout_sel == 2'h2 && mode_reg[DPC_LOAD_B_BIT])) begin
				tout_reg <= 1'b1;
			end else if ((tout_sel == 2'h1 && sts_a.eoc) ||
			             (tout_sel == 2'h2 && sts_b.eoc)) begin
				tout_reg <= !tout_reg;
			end
		end
	end
	a_load_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_mode && reg_wdata[DPC_LOAD_A_BIT] ##1 !wr_mode |=> !mode_reg[DPC_LOAD_A_BIT])
		else $error("Load bit did not self-clear");
	a_pre_reads_ones: assert property (@(posedge ref_clk) disable iff (!rst_b)
		reg_rd && reg_addr == DPC_PRE_A_ADDR |=> reg_rdata == 8'hff)
		else $error("Prescaler read not all ones");
	a_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sts_a.eoc |=> counter_a_irq)
		else $error("Interrupt missing after end of count");
	a_tout_toggle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		tout_sel == 2'h1 && sts_a.eoc && !mode_reg[DPC_LOAD_A_BIT] |=> timer_output != $past(timer_output))
		else $error("Timer output did not toggle");
	a_first_decr: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(en_hist_reg[0]) && !mode_reg[DPC_LOAD_A_BIT] |-> ##[0:4] tick_int)
		else $error("No decrement slot within four clocks");
endmodule // dpc_top
`default_nettype wire

// ==== testbench/dpc_top_tb_top.sv ====
// Self-checking testbench for the dual prescaled down-counter.
// Assumes dpc_pkg and dpc_top are compiled first; 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dpc_top_tb_top;
	import dpc_pkg::*;
	logic       ref_clk              = 1'b0;
	logic       rst_b                = 1'b0;
	logic [7:0] reg_addr             = 8'h00;
	logic       reg_wr               = 1'b0;
	logic       reg_rd               = 1'b0;
	logic [7:0] reg_wdata            = 8'h00;
	logic       external_count_input = 1'b1;
	logic [7:0] reg_rdata;
	logic       counter_a_irq;
	logic       counter_b_irq;
	logic       timer_output;
	int         n_fail               = 0;
	int         compares             = 0;
	int         na;
	int         nb;
	int         n;
	logic [7:0] v1;
	logic [7:0] v2;

	always #10 ref_clk = ~ref_clk;

	dpc_top i_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.external_count_input(external_count_input), .counter_a_irq(counter_a_irq),
		.counter_b_irq(counter_b_irq), .timer_output(timer_output)
	);

	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		@(posedge ref_clk);
		#1 d = reg_rdata;
	endtask

	// Count interrupt pulses over a number of cycles
	task automatic run(int cyc);
		na = 0;
		nb = 0;
		repeat (cyc) begin
			@(posedge ref_clk);
			#1;
			na += (counter_a_irq === 1'b1);
			nb += (counter_b_irq === 1'b1);
		end
	endtask

	// Cycles until the next counter A interrupt, bounded
	task automatic wait_a();
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (counter_a_irq !== 1'b1 && n < 2000);
	endtask

	task automatic t_reads();
		rd(DPC_PRE_A_ADDR, v1);
		check("prescaler_a read", 8'hff, v1);
		rd(DPC_PRE_B_ADDR, v1);
		check("prescaler_b read", 8'hff, v1);
		rd(8'h10, v1);
		check("unmapped read", 8'hff, v1);
	endtask

	task automatic t_cont_a();
		wr(DPC_CNT_A_ADDR, 8'h03);
		wr(DPC_PRE_A_ADDR, 8'h05);
		wr(DPC_MODE_ADDR, 8'h41);
		rd(DPC_CNT_A_ADDR, v1);
		check("loaded count", 8'h03, v1);
		check("tout after load", 1'b1, timer_output);
		run(20);
		rd(DPC_CNT_A_ADDR, v1);
		check("held count", 8'h03, v1);
		wr(DPC_MODE_ADDR, 8'h42);
		wait_a();
		check("first end in window", 1'b1, n >= 8 && n <= 15);
		repeat (2) @(posedge ref_clk);
		#1 check("tout toggled low", 1'b0, timer_output);
		wait_a();
		check("continuous period", 16'd12, n + 2);
		repeat (2) @(posedge ref_clk);
		#1 check("tout toggled high", 1'b1, timer_output);
	endtask

	// Retrigger with new values while running, then measure the period
	task automatic t_periods();
		logic [7:0] ini [3] = '{8'h01, 8'h00, 8'h02};
		logic [7:0] pre [3] = '{8'h09, 8'h05, 8'hfd};
		int         per [3] = '{8, 1024, 504};
		for (int i = 0; i < 3; i++) begin
			wr(DPC_CNT_A_ADDR, ini[i]);
			wr(DPC_PRE_A_ADDR, pre[i]);
			wr(DPC_MODE_ADDR, 8'h03);
			wait_a();
			wait_a();
			check("period", per[i], n);
		end
	endtask

	task automatic t_single();
		wr(DPC_CNT_A_ADDR, 8'h02);
		wr(DPC_PRE_A_ADDR, 8'h04);
		wr(DPC_MODE_ADDR, 8'h03);
		wait_a();
		check("single end in window", 1'b1, n <= 16);
		run(100);
		check("single extra irqs", 16'd0, na);
		rd(DPC_CNT_A_ADDR, v1);
		check("single rest value", 8'h00, v1);
	endtask

	task automatic t_freeze();
		wr(DPC_CNT_A_ADDR, 8'h40);
		wr(DPC_PRE_A_ADDR, 8'h05);
		wr(DPC_MODE_ADDR, 8'h03);
		run(40);
		wr(DPC_MODE_ADDR, 8'h00);
		rd(DPC_CNT_A_ADDR, v1);
		run(30);
		rd(DPC_CNT_A_ADDR, v2);
		check("frozen count", v1, v2);
		wr(DPC_MODE_ADDR, 8'h02);
		run(40);
		rd(DPC_CNT_A_ADDR, v2);
		check("resumed steps", 1'b1, v1 - v2 >= 8'd9 && v1 - v2 <= 8'd12);
	endtask

	task automatic t_ext_b();
		int tot;
		tot = 0;
		wr(DPC_CNT_B_ADDR, 8'h02);
		wr(DPC_PRE_B_ADDR, 8'h07);
		wr(DPC_MODE_ADDR, 8'h0c);
		run(30);
		check("no ext edges irq_b", 16'd0, nb);
		check("stopped irq_a", 16'd0, na);
		repeat (4) begin
			external_count_input <= 1'b0;
			run(8);
			tot += nb;
			external_count_input <= 1'b1;
			run(8);
			tot += nb;
		end
		check("ext edge irq_b", 16'd2, tot);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reads();
		t_cont_a();
		t_periods();
		t_single();
		t_freeze();
		t_ext_b();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		end_of_test();
	end
endmodule // dpc_top_tb_top
`default_nettype wire
